/* File: logic/pcs_core.sv */
`timescale 1ns/1ps
// Contract
// - program counter is a 13-bit register selecting next instruction
// - counter low byte readable and writable by instructions
// - counter bits 12..8 hidden, loaded from high-byte latch, jump operand bits 10..8 or return stack
// - any reset clears the whole program counter
// - low-byte write loads upper bits from latch bits 4..0
// - call or jump takes top two counter bits from latch bits 4..3
// - eight-deep 13-bit return stack, pointer hidden from software
// - call pushes counter plus one, interrupt vectoring pushes current counter
// - return, return-with-literal, return-from-interrupt pop into counter
// - push and pop leave high-byte latch unchanged
// - stack wraps circularly, ninth push overwrites first
// - no stack overflow or underflow flag exists
// - indirect port is not storage, accesses file-pointer location
// - indirect read with pointer at the port returns zero
// - indirect write with pointer at the port stores nothing
// - indirect address is bank-select bit above eight pointer bits
// - bank-select set picks banks 2-3, clear picks banks 0-1

module pcs_core #(
  parameter int DEPTH = pcs_pkg::STACK_DEPTH,
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcs_pkg::pcs_flow_t flow,
  input wire logic low_wr,
  input wire logic [7:0] low_wdata,
  input wire logic latch_wr,
  input wire logic [7:0] latch_wdata,
  input wire logic fptr_wr,
  input wire logic [7:0] fptr_wdata,
  input wire logic bank_select,
  input wire pcs_pkg::pcs_data_req_t dreq,
  input wire logic [7:0] mem_rdata,
  output logic [12:0] program_counter,
  output logic [7:0] counter_low_byte_reg,
  output logic [7:0] counter_high_latch,
  output logic [7:0] file_pointer_reg,
  output pcs_pkg::pcs_mem_req_t mem_req,
  output logic [7:0] ind_rdata,
  output logic ind_rvalid
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH != pcs_pkg::STACK_DEPTH) begin
      $error("return stack depth is fixed by the core");
    end
  end

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [12:0] jump_target(
    input logic [7:0] latch,
    input logic [10:0] operand
  );
    return {latch[pcs_pkg::LATCH_PAGE_HI:pcs_pkg::LATCH_PAGE_LO], operand};
  endfunction

  function automatic logic [8:0] ind_addr(
    input logic bank,
    input logic [7:0] fptr
  );
    return {bank, fptr};
  endfunction

  logic [12:0] pc_q;
  logic [12:0] pc_d;
  logic [7:0] latch_q;
  logic [7:0] fptr_q;
  logic [PW-1:0] sp_q;
  logic [PW-1:0] sp_d;
  logic push;
  logic pop;
  logic [12:0] stack_top;
  logic pop_pend_q;
  logic [12:0] pc_plus;
  logic ind_hit;
  logic ind_self;
  logic [8:0] eff_addr;
  logic rd_pend_q;
  logic self_pend_q;
  logic rd_pend2_q;
  logic self_pend2_q;

  assign pc_plus = pc_q + 13'h0001;

  // ****************************************************
  // stack control
  // ****************************************************
  // push on call or interrupt vectoring
  assign push = (flow.op == pcs_pkg::PCS_OP_CALL) ||
                (flow.op == pcs_pkg::PCS_OP_INTVEC);
  assign pop = (flow.op == pcs_pkg::PCS_OP_RET) ||
               (flow.op == pcs_pkg::PCS_OP_RETLIT) ||
               (flow.op == pcs_pkg::PCS_OP_RETINT);

  always_comb begin
    sp_d = sp_q;
    if (push) begin
      sp_d = sp_q + PW'(1);
    end else if (pop) begin
      sp_d = sp_q - PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_q <= '0;
    end else begin
      sp_q <= sp_d;
    end
  end

  pcs_stack_mem #(
    .DEPTH(DEPTH),
    .WIDTH(pcs_pkg::PC_W)
  ) u_stack (
    .clk(clk),
    .wr_en(push),
    .wr_addr(sp_q),
    .wr_data(flow.op == pcs_pkg::PCS_OP_CALL ? pc_plus : pc_q),
    .rd_addr(sp_q - PW'(1)),
    .rd_data(stack_top)
  );

  // pop completes one cycle later from the registered read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pop_pend_q <= 1'b0;
    end else begin
      pop_pend_q <= pop;
    end
  end

  // ****************************************************
  // program counter
  // ****************************************************
  always_comb begin
    pc_d = pc_plus;
    if (pop_pend_q) begin
      pc_d = stack_top;
    end else begin
      case (flow.op)
        pcs_pkg::PCS_OP_JUMP, pcs_pkg::PCS_OP_CALL: begin
          pc_d = jump_target(latch_q, flow.target);
        end
        pcs_pkg::PCS_OP_INTVEC: begin
          pc_d = INT_VECTOR;
        end
        pcs_pkg::PCS_OP_RET, pcs_pkg::PCS_OP_RETLIT,
        pcs_pkg::PCS_OP_RETINT, pcs_pkg::PCS_OP_HOLD: begin
          pc_d = pc_q;
        end
        default: begin
          if (low_wr) begin
            pc_d = {latch_q[pcs_pkg::HIGH_W-1:0], low_wdata};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= pcs_pkg::PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ****************************************************
  // latch and file pointer
  // ****************************************************
  // latch written only by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= pcs_pkg::LATCH_RESET;
    end else if (latch_wr) begin
      latch_q <= latch_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fptr_q <= pcs_pkg::FPTR_RESET;
    end else if (fptr_wr) begin
      fptr_q <= fptr_wdata;
    end
  end

  // ****************************************************
  // indirect addressing
  // ****************************************************
  // port redirects, no storage
  assign ind_hit = (dreq.addr == pcs_pkg::INDIRECT_ADDR);
  assign ind_self = (fptr_q == pcs_pkg::INDIRECT_ADDR);
  assign eff_addr = ind_hit ? ind_addr(bank_select, fptr_q) :
                    {1'b0, dreq.addr};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req.addr <= eff_addr;
      mem_req.wdata <= dreq.wdata;
      mem_req.rd <= dreq.rd && !(ind_hit && ind_self);
      mem_req.wr <= dreq.wr && !(ind_hit && ind_self);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      self_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= dreq.rd && ind_hit;
      self_pend_q <= dreq.rd && ind_hit && ind_self;
    end
  end

  // memory answers the cycle after its request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend2_q <= 1'b0;
      self_pend2_q <= 1'b0;
    end else begin
      rd_pend2_q <= rd_pend_q;
      self_pend2_q <= self_pend_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ind_rdata <= 8'h00;
      ind_rvalid <= 1'b0;
    end else begin
      ind_rvalid <= rd_pend2_q;
      ind_rdata <= self_pend2_q ? pcs_pkg::INDIRECT_READ_VALUE : mem_rdata;
    end
  end

  // ****************************************************
  // registered views
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_counter <= pcs_pkg::PC_RESET;
    end else begin
      program_counter <= pc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_low_byte_reg <= 8'h00;
    end else begin
      counter_low_byte_reg <= pc_d[pcs_pkg::LOW_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_high_latch <= pcs_pkg::LATCH_RESET;
    end else begin
      counter_high_latch <= latch_wr ? latch_wdata : latch_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      file_pointer_reg <= pcs_pkg::FPTR_RESET;
    end else begin
      file_pointer_reg <= fptr_wr ? fptr_wdata : fptr_q;
    end
  end

endmodule

/* File: logic/pcs_pkg.sv */
package pcs_pkg;

  // ****************************************************
  // widths and sizes
  // ****************************************************
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 5;
  localparam int JUMP_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int DADDR_W = 9;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;
  localparam int BANK_SEL_POS = 7;

  // ****************************************************
  // reset values and special codes
  // ****************************************************
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] FPTR_RESET = 8'h00;
  localparam logic [7:0] INDIRECT_ADDR = 8'h00;
  localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;

  // ****************************************************
  // program-flow commands from the decoder
  // ****************************************************
  typedef enum logic [2:0] {
    PCS_OP_STEP = 3'h0,
    PCS_OP_JUMP = 3'h1,
    PCS_OP_CALL = 3'h2,
    PCS_OP_RET = 3'h3,
    PCS_OP_RETLIT = 3'h4,
    PCS_OP_RETINT = 3'h5,
    PCS_OP_INTVEC = 3'h6,
    PCS_OP_HOLD = 3'h7
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t op;
    logic [10:0] target;
  } pcs_flow_t;

  // data-side request from the decoder
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcs_data_req_t;

  // request toward data memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pcs_mem_req_t;

endpackage

/* File: logic/pcs_stack_mem.sv */
`timescale 1ns/1ps

module pcs_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("stack depth must be a power of two");
    end
  end

  // ****************************************************
  // storage with registered read
  // ****************************************************
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: verification/pcs_core_assertions.sv */
`timescale 1ns/1ps
module pcs_core_assertions #(
  parameter int DEPTH = 8,
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcs_pkg::pcs_flow_t flow,
  input wire logic low_wr,
  input wire logic [7:0] low_wdata,
  input wire logic latch_wr,
  input wire logic [7:0] latch_wdata,
  input wire logic fptr_wr,
  input wire logic [7:0] fptr_wdata,
  input wire logic bank_select,
  input wire pcs_pkg::pcs_data_req_t dreq,
  input wire logic [7:0] mem_rdata,
  input wire logic [12:0] program_counter,
  input wire logic [7:0] counter_low_byte_reg,
  input wire logic [7:0] counter_high_latch,
  input wire logic [7:0] file_pointer_reg,
  input wire pcs_pkg::pcs_mem_req_t mem_req,
  input wire logic [7:0] ind_rdata,
  input wire logic ind_rvalid
);
  // ******
  // helpers
  // ******
  logic ret_q;
  wire is_ret = flow.op inside {[3'h3:3'h5]};
  wire is_call = flow.op == pcs_pkg::PCS_OP_CALL;
  wire ind0 = dreq.addr == 8'h00 && file_pointer_reg == 8'h00;
  wire [1:0] page = counter_high_latch[4:3];
  wire [4:0] upper = counter_high_latch[4:0];
  always_ff @(posedge clk) begin
    ret_q <= rst_n && is_ret;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ******
  // properties
  // ******
  property p_reset;
    disable iff (1'b0) !rst_n |=> program_counter == 13'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("pc not cleared");
  property p_step;
    flow.op == pcs_pkg::PCS_OP_STEP && !low_wr && !ret_q
      |=> program_counter == $past(program_counter) + 13'h0001;
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_jump;
    flow.op == pcs_pkg::PCS_OP_JUMP && !ret_q
      |=> program_counter == {$past(page), $past(flow.target)};
  endproperty
  a_jump: assert property (p_jump) else $error("bad jump");
  property p_low;
    flow.op == pcs_pkg::PCS_OP_STEP && low_wr && !ret_q
      |=> program_counter == {$past(upper), $past(low_wdata)};
  endproperty
  a_low: assert property (p_low) else $error("bad low write");
  property p_callret;
    (is_call && !ret_q) ##1 is_ret
      |-> ##2 program_counter == $past(program_counter, 3) + 13'h0001;
  endproperty
  a_callret: assert property (p_callret) else $error("bad pop");
  property p_latch;
    (is_call || is_ret) && !latch_wr |=> $stable(counter_high_latch);
  endproperty
  a_latch: assert property (p_latch) else $error("latch moved");
  property p_iaddr;
    dreq.wr && dreq.addr == 8'h00 && !ind0 |=> mem_req.wr &&
      mem_req.addr == {$past(bank_select), $past(file_pointer_reg)};
  endproperty
  a_iaddr: assert property (p_iaddr) else $error("bad address");
  property p_inomem;
    (dreq.rd || dreq.wr) && ind0 |=> !mem_req.rd && !mem_req.wr;
  endproperty
  a_inomem: assert property (p_inomem) else $error("self access");
  property p_izero;
    dreq.rd && ind0 |-> ##[1:3] ind_rvalid && ind_rdata == 8'h00;
  endproperty
  a_izero: assert property (p_izero) else $error("nonzero read");
  property p_ivec;
    flow.op == pcs_pkg::PCS_OP_INTVEC && !ret_q
      |=> program_counter == INT_VECTOR;
  endproperty
  a_ivec: assert property (p_ivec) else $error("bad vector");
  c_callret: cover property (is_call ##1 is_ret);
  c_izero: cover property (dreq.rd && ind0);
  c_ivec: cover property (flow.op == pcs_pkg::PCS_OP_INTVEC);
endmodule

/* File: verification/pcs_mem_model.sv */
`timescale 1ns/1ps
module pcs_mem_model (
  input wire logic clk,
  input wire pcs_pkg::pcs_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [512];
  initial mem_rdata = 8'h00;
  // ******
  // store and answer, stale data inverted
  // ******
  always @(posedge clk) begin
    if (mem_req.wr) begin
      ram[mem_req.addr] <= mem_req.wdata;
    end
    mem_rdata <= mem_req.rd ? ram[mem_req.addr] : ~mem_rdata;
  end
endmodule

/* File: verification/test_program_counter_stack_indirect.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
  check_count++; \
  if ((s) !== (e)) begin \
    err_total++; \
    $display("Error %s exp %0h got %0h", nm, e, s); \
  end \
end
bind pcs_core pcs_core_assertions #(
  .DEPTH(DEPTH),
  .INT_VECTOR(INT_VECTOR)
) u_chk (
  .clk, .rst_n, .flow, .low_wr, .low_wdata, .latch_wr, .latch_wdata,
  .fptr_wr, .fptr_wdata, .bank_select, .dreq, .mem_rdata,
  .program_counter, .counter_low_byte_reg, .counter_high_latch,
  .file_pointer_reg, .mem_req, .ind_rdata, .ind_rvalid
);
module test_program_counter_stack_indirect;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcs_pkg::pcs_flow_t flow = '{pcs_pkg::PCS_OP_HOLD, 11'h000};
  logic low_wr = 1'b0;
  logic [7:0] low_wdata = 8'h00;
  logic latch_wr = 1'b0;
  logic [7:0] latch_wdata = 8'h00;
  logic fptr_wr = 1'b0;
  logic [7:0] fptr_wdata = 8'h00;
  logic bank_select = 1'b0;
  pcs_pkg::pcs_data_req_t dreq = '0;
  logic [7:0] mem_rdata;
  logic [12:0] program_counter;
  logic [7:0] counter_low_byte_reg;
  logic [7:0] counter_high_latch;
  logic [7:0] file_pointer_reg;
  pcs_pkg::pcs_mem_req_t mem_req;
  pcs_pkg::pcs_mem_req_t mr;
  logic [7:0] ind_rdata;
  logic ind_rvalid;
  logic [7:0] rv_d;
  logic [12:0] exp_pc;
  int err_total = 0;
  int check_count = 0;
  int rv_n = 0;
  int mr_n = 0;
  pcs_core #(.INT_VECTOR(13'h0004)) DUT (
    .clk, .rst_n, .flow, .low_wr, .low_wdata, .latch_wr, .latch_wdata,
    .fptr_wr, .fptr_wdata, .bank_select, .dreq, .mem_rdata,
    .program_counter, .counter_low_byte_reg, .counter_high_latch,
    .file_pointer_reg, .mem_req, .ind_rdata, .ind_rvalid
  );
  pcs_mem_model u_mem (.clk, .mem_req, .mem_rdata);
  always #25 clk = ~clk;
  // ******
  // monitors and drivers
  // ******
  always @(posedge clk) begin
    if (ind_rvalid === 1'b1) begin
      rv_d <= ind_rdata;
      rv_n <= rv_n + 1;
    end
    if (mem_req.rd === 1'b1 || mem_req.wr === 1'b1) begin
      mr <= mem_req;
      mr_n <= mr_n + 1;
    end
  end
  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input pcs_pkg::pcs_op_t op, input logic [10:0] t);
    flow = '{op, t};
    @(negedge clk);
    flow.op = pcs_pkg::PCS_OP_HOLD;
    @(negedge clk);
  endtask
  task automatic set_regs(input logic l, input logic [7:0] v);
    latch_wr = l;
    fptr_wr = !l;
    latch_wdata = v;
    fptr_wdata = v;
    @(negedge clk);
    latch_wr = 1'b0;
    fptr_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic dacc(input logic r, input logic w, input logic [7:0] d);
    int n0;
    int k;
    n0 = rv_n;
    k = 0;
    dreq = '{r, w, 8'h00, d};
    @(negedge clk);
    dreq = '0;
    while (r && rv_n == n0) begin
      k++;
      if (k > 6) begin
        err_total++;
        report_and_stop();
      end
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_reset;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    exp_pc = 13'h0000;
    `CHK("reset", 13'h0000, program_counter)
  endtask
  task automatic t_flow;
    set_regs(1'b1, 8'h1F);
    cmd(pcs_pkg::PCS_OP_JUMP, 11'h123);
    `CHK("jump", 13'h1923, program_counter)
    cmd(pcs_pkg::PCS_OP_STEP, 11'h000);
    `CHK("step", 13'h1924, program_counter)
    low_wr = 1'b1;
    low_wdata = 8'hA5;
    cmd(pcs_pkg::PCS_OP_STEP, 11'h000);
    low_wr = 1'b0;
    `CHK("low", 13'h1FA5, program_counter)
    `CHK("lowreg", 8'hA5, counter_low_byte_reg)
    exp_pc = 13'h1FA5;
  endtask
  task automatic t_calls;
    set_regs(1'b1, 8'h08);
    for (int k = 0; k < 3; k++) begin
      flow = '{pcs_pkg::PCS_OP_CALL, 11'h010};
      @(negedge clk);
      `CHK("call", 13'h0810, program_counter)
      flow.op = pcs_pkg::pcs_op_t'(k[2:0] + 3'h3);
      @(negedge clk);
      flow.op = pcs_pkg::PCS_OP_HOLD;
      @(negedge clk);
      exp_pc++;
      `CHK("ret", exp_pc, program_counter)
      `CHK("latch", 8'h08, counter_high_latch)
    end
    cmd(pcs_pkg::PCS_OP_INTVEC, 11'h000);
    `CHK("ivec", 13'h0004, program_counter)
    cmd(pcs_pkg::PCS_OP_RETINT, 11'h000);
    `CHK("reti", exp_pc, program_counter)
  endtask
  task automatic t_wrap;
    logic [12:0] st [10];
    for (int i = 0; i < 10; i++) begin
      st[i] = exp_pc + 13'h0001;
      exp_pc = {2'b01, 11'(i)};
      cmd(pcs_pkg::PCS_OP_CALL, 11'(i));
    end
    for (int i = 9; i > 1; i--) begin
      cmd(pcs_pkg::PCS_OP_RET, 11'h000);
      `CHK("pop", st[i], program_counter)
    end
  endtask
  task automatic t_ind;
    set_regs(1'b0, 8'h40);
    `CHK("fptr", 8'h40, file_pointer_reg)
    for (int b = 0; b < 2; b++) begin
      bank_select = b[0];
      dacc(1'b0, 1'b1, 8'h5A + 8'(b));
      `CHK("iwr", 1'b1, mr.wr)
      `CHK("iaddr", {b[0], 8'h40}, mr.addr)
      `CHK("iwdata", 8'h5A + 8'(b), mr.wdata)
    end
    for (int b = 0; b < 2; b++) begin
      bank_select = b[0];
      dacc(1'b1, 1'b0, 8'h00);
      `CHK("ird", 1'b1, mr.rd)
      `CHK("idata", 8'h5A + 8'(b), rv_d)
    end
  endtask
  task automatic t_izero;
    int n;
    set_regs(1'b0, 8'h00);
    n = mr_n;
    dacc(1'b1, 1'b0, 8'h00);
    `CHK("izero", 8'h00, rv_d)
    dacc(1'b0, 1'b1, 8'h77);
    `CHK("nomem", n, mr_n)
  endtask
  initial begin
    repeat (5000) @(negedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    t_reset();
    t_flow();
    t_calls();
    t_wrap();
    t_ind();
    t_izero();
    t_reset();
    report_and_stop();
  end
endmodule
